/* shared/psp_defs.svh */
// Purpose: offsets, field positions and reset values of the slave port.
// Assumes: word-aligned Wishbone byte addresses, 8-bit data in low lanes.
// Notes:   Definitions only.
`ifndef PSP_DEFS_SVH
`define PSP_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PSP_OFF_OUT0 6'h00
`define PSP_OFF_OUT1 6'h04
`define PSP_OFF_OUT2 6'h08
`define PSP_OFF_IN0 6'h0c
`define PSP_OFF_IN1 6'h10
`define PSP_OFF_IN2 6'h14
`define PSP_OFF_STAT 6'h18
`define PSP_OFF_CTRL 6'h1c
`define PSP_OFF_IRQ_STAT 6'h20
`define PSP_OFF_IRQ_EN 6'h24
`define PSP_OFF_IRQ_CLR 6'h28
`define PSP_OFF_PORTA 6'h2c

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define PSP_CTRL_SLAVE_EN 0
`define PSP_CTRL_ATTN_CLR 1
`define PSP_STAT_PEND_LSB 3
`define PSP_IRQ_IN_LSB 0
`define PSP_IRQ_OUT_READ 3
`define PSP_RST_BYTE 8'h00
`define PSP_RST_CTRL 8'h00
`define PSP_RST_IRQ 4'h0
`define PSP_NUM_REGS 3

`endif

/* shared/psp_pkg.sv */
// Purpose: types shared by the slave port modules.
// Assumes: nothing beyond the defines header.
// Notes:   Select codes 0..2 are the three registers; 3 is unused.
package psp_pkg;
  typedef logic [7:0] psp_byte_type;
  typedef logic [1:0] psp_sel_type;
  typedef enum logic [1:0] {
    PSP_BUS_IDLE,
    PSP_BUS_ACK
  } psp_bus_state_type;
endpackage : psp_pkg

/* src/psp_flag.sv */
// Purpose: one sticky flag with set over clear priority.
// Assumes: set and clear are one-cycle pulses on clk_i.
// Notes:   Used for inbound written flags, pending flags, attention and irq status.
`timescale 1ns/1ps
module psp_flag (
  input wire logic clk_i,  // System clock
  input wire logic rst_i,  // Sync reset, high
  input wire logic set_i,  // Set pulse
  input wire logic clr_i,  // Clear pulse
  output logic flag_o      // Sticky flag
);
  logic flag_ff;
  logic nxt_flag;

  // Set wins so an event in the clear cycle is not lost
  assign nxt_flag = set_i | (flag_ff & ~clr_i);
  assign flag_o = flag_ff;

  // Flag register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end
endmodule : psp_flag

/* src/psp_edge.sv */
// Purpose: assertion (falling level) and release edge detector for an active-low strobe.
// Assumes: strobe is synchronous to clk_i.
// Notes:   Pulses once at strobe assertion, so a long strobe counts once.
`timescale 1ns/1ps
module psp_edge (
  input wire logic clk_i,   // System clock
  input wire logic rst_i,   // Sync reset, high
  input wire logic strb_n_i, // Strobe, low active
  output logic rise_o,      // Assertion pulse
  output logic fall_o       // Release pulse
);
  logic prev_ff;

  // Previous level, idle is high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_ff <= 1'b1;
    end else begin
      prev_ff <= strb_n_i;
    end
  end

  assign rise_o = prev_ff & ~strb_n_i;
  assign fall_o = ~prev_ff & strb_n_i;
endmodule : psp_edge

/* src/psp_top.sv */
// Purpose: parallel slave port with a Wishbone register file.
// Assumes: master pins synchronous to clk_i; one clock domain.
// Notes:   Data pins are shared with parallel port A; enables low drive.
//
// Added by the designer: the register addresses and register access over Wishbone.
`include "psp_defs.svh"
`timescale 1ns/1ps
module psp_top (
  input wire logic clk_i,               // System clock
  input wire logic rst_i,               // Sync reset, high
  // Wishbone slave
  input wire logic wb_cyc_i,            // Bus cycle
  input wire logic wb_stb_i,            // Strobe
  input wire logic wb_we_i,             // Write enable
  input wire logic [5:0] wb_adr_i,      // Byte address
  input wire logic [3:0] wb_sel_i,      // Byte enables
  input wire logic [31:0] wb_dat_i,     // Write data
  output logic [31:0] wb_dat_o,         // Read data
  output logic wb_ack_o,                // Acknowledge
  output logic wb_err_o,                // Unmapped address
  // Master side
  input wire psp_pkg::psp_sel_type sel_i, // Register select
  input wire logic rd_n_i,              // Read strobe, low
  input wire logic wr_n_i,              // Write strobe, low
  input wire psp_pkg::psp_byte_type pd_i, // Pin data in
  output psp_pkg::psp_byte_type pd_o,   // Pin data out
  output logic [7:0] pd_oe_n_o,         // Pin enable, low drives
  output logic attn_o,                  // Attention to master
  output logic in_empty_o,              // All inbound read
  output logic out_pend_o,              // Outbound waiting
  output logic irq_o                    // Local interrupt
);
  import psp_pkg::*;

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  psp_bus_state_type bus_ff;
  psp_bus_state_type nxt_bus;
  logic [31:0] rdat_ff;
  logic [31:0] nxt_rdat;
  logic err_ff;
  logic nxt_err;
  wire req = wb_cyc_i & wb_stb_i & (bus_ff == PSP_BUS_IDLE);
  wire lane0 = wb_sel_i[0];
  wire hit_out0 = wb_adr_i == `PSP_OFF_OUT0;
  wire hit_out1 = wb_adr_i == `PSP_OFF_OUT1;
  wire hit_out2 = wb_adr_i == `PSP_OFF_OUT2;
  wire hit_in0 = wb_adr_i == `PSP_OFF_IN0;
  wire hit_in1 = wb_adr_i == `PSP_OFF_IN1;
  wire hit_in2 = wb_adr_i == `PSP_OFF_IN2;
  wire hit_stat = wb_adr_i == `PSP_OFF_STAT;
  wire hit_ctrl = wb_adr_i == `PSP_OFF_CTRL;
  wire hit_ist = wb_adr_i == `PSP_OFF_IRQ_STAT;
  wire hit_ien = wb_adr_i == `PSP_OFF_IRQ_EN;
  wire hit_icl = wb_adr_i == `PSP_OFF_IRQ_CLR;
  wire hit_pa = wb_adr_i == `PSP_OFF_PORTA;
  wire hit_any = hit_out0 | hit_out1 | hit_out2 | hit_in0 | hit_in1 |
                 hit_in2 | hit_stat | hit_ctrl | hit_ist | hit_ien |
                 hit_icl | hit_pa;
  wire bwr = req & wb_we_i & lane0;
  wire brd = req & ~wb_we_i;
  wire [7:0] wbyte = wb_dat_i[7:0];

  // Per-register local strobes
  wire [2:0] out_wr = {bwr & hit_out2, bwr & hit_out1, bwr & hit_out0};
  wire [2:0] in_rd = {brd & hit_in2, brd & hit_in1, brd & hit_in0};
  wire ctrl_wr = bwr & hit_ctrl;
  wire ien_wr = bwr & hit_ien;
  wire icl_wr = bwr & hit_icl;
  wire pa_wr = bwr & hit_pa;

  // --------------------------------------------------------------------
  // Control and parallel port A
  // --------------------------------------------------------------------
  logic [7:0] ctrl_ff;
  logic [7:0] pa_ff;
  logic [3:0] ien_ff;
  wire slave_en = ctrl_ff[`PSP_CTRL_SLAVE_EN];

  // Software writes; attention clear bit is self clearing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= `PSP_RST_CTRL;
      pa_ff <= `PSP_RST_BYTE;
      ien_ff <= `PSP_RST_IRQ;
    end else begin
      if (ctrl_wr) ctrl_ff <= wbyte & 8'h01;
      if (pa_wr) pa_ff <= wbyte;
      if (ien_wr) ien_ff <= wbyte[3:0];
    end
  end
  wire attn_clr = ctrl_wr & wbyte[`PSP_CTRL_ATTN_CLR];

  // --------------------------------------------------------------------
  // Master strobes
  // --------------------------------------------------------------------
  logic rd_fall;
  logic wr_rise;
  // Read assertion edge unused; pins follow the strobe level instead
  psp_edge u_rd_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .strb_n_i(rd_n_i),
    .rise_o(),
    .fall_o(rd_fall)
  );
  psp_edge u_wr_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .strb_n_i(wr_n_i),
    .rise_o(wr_rise),
    .fall_o()
  );
  // Select 3 addresses nothing; strobes ignored out of slave mode
  wire sel_ok = sel_i != 2'd3;
  wire [2:0] sel_dec = 3'b001 << sel_i;
  wire [2:0] m_wr = (slave_en & wr_rise & sel_ok) ? sel_dec : 3'b000;
  // Read counted at strobe release so data was seen on the pins
  wire [2:0] m_rd = (slave_en & rd_fall & sel_ok) ? sel_dec : 3'b000;

  // --------------------------------------------------------------------
  // Six data registers, 8 bits each
  // --------------------------------------------------------------------
  psp_byte_type out_ff [`PSP_NUM_REGS];
  psp_byte_type in_ff [`PSP_NUM_REGS];
  logic [2:0] in_flag;
  logic [2:0] pend_flag;

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < `PSP_NUM_REGS; i++) begin
      if (rst_i) begin
        out_ff[i] <= `PSP_RST_BYTE;
        in_ff[i] <= `PSP_RST_BYTE;
      end else begin
        if (out_wr[i]) out_ff[i] <= wbyte;
        if (m_wr[i]) in_ff[i] <= pd_i;
      end
    end
  end

  // Written and pending flags, one each per register
  for (genvar g = 0; g < `PSP_NUM_REGS; g++) begin : g_flag
    psp_flag u_in (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .set_i(m_wr[g]),
      .clr_i(in_rd[g]),
      .flag_o(in_flag[g])
    );
    psp_flag u_pend (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .set_i(out_wr[g]),
      .clr_i(m_rd[g]),
      .flag_o(pend_flag[g])
    );
  end

  // --------------------------------------------------------------------
  // Handshake lines to the master
  // --------------------------------------------------------------------
  psp_flag u_attn (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(|out_wr),
    .clr_i(attn_clr | (|m_rd)),
    .flag_o(attn_o)
  );
  assign in_empty_o = ~(|in_flag);
  assign out_pend_o = |pend_flag;

  // --------------------------------------------------------------------
  // Pin drive: slave mode takes over port A
  // --------------------------------------------------------------------
  // Drive only while read strobe low; avoids a fight with a writing master
  wire slave_drive = slave_en & ~rd_n_i & sel_ok;
  wire pa_drive = ~slave_en;
  psp_byte_type pd_ff;
  logic oe_n_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pd_ff <= `PSP_RST_BYTE;
      oe_n_ff <= 1'b1;
    end else begin
      pd_ff <= slave_drive ? out_ff[sel_i] : pa_ff;
      oe_n_ff <= ~(slave_drive | pa_drive);
    end
  end
  assign pd_o = pd_ff;
  assign pd_oe_n_o = {8{oe_n_ff}};

  // --------------------------------------------------------------------
  // Interrupts: inbound writes and outbound fetched
  // --------------------------------------------------------------------
  logic [3:0] ist;
  wire [3:0] ev = {|m_rd, m_wr};
  for (genvar k = 0; k < 4; k++) begin : g_irq
    psp_flag u_ist (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .set_i(ev[k]),
      .clr_i(icl_wr & wbyte[k]),
      .flag_o(ist[k])
    );
  end
  assign irq_o = |(ist & ien_ff);

  // --------------------------------------------------------------------
  // Read mux and acknowledge
  // --------------------------------------------------------------------
  wire [7:0] stat_val = {2'b00, pend_flag, in_flag};
  wire [7:0] sel_in = hit_in0 ? in_ff[0] : hit_in1 ? in_ff[1] : in_ff[2];
  wire [7:0] sel_out = hit_out0 ? out_ff[0] :
                       hit_out1 ? out_ff[1] : out_ff[2];
  // Inbound read returns data and clears its flag in one access
  wire [7:0] rbyte =
    (hit_in0 | hit_in1 | hit_in2) ? sel_in :
    (hit_out0 | hit_out1 | hit_out2) ? sel_out :
    hit_stat ? stat_val :
    hit_ctrl ? ctrl_ff :
    hit_ist ? {4'h0, ist} :
    hit_ien ? {4'h0, ien_ff} :
    hit_pa ? pd_i : 8'h00;

  assign nxt_bus = req ? PSP_BUS_ACK : PSP_BUS_IDLE;
  assign nxt_rdat = brd ? {24'h000000, rbyte} : 32'h00000000;
  assign nxt_err = req & ~hit_any;

  // One-cycle registered answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_ff <= PSP_BUS_IDLE;
      rdat_ff <= 32'h00000000;
      err_ff <= 1'b0;
    end else begin
      bus_ff <= nxt_bus;
      rdat_ff <= nxt_rdat;
      err_ff <= nxt_err;
    end
  end

  // Answer decode
  always_comb begin
    case (bus_ff)
      PSP_BUS_ACK: begin
        wb_ack_o = ~err_ff;
        wb_err_o = err_ff;
      end
      default: begin
        wb_ack_o = 1'b0;
        wb_err_o = 1'b0;
      end
    endcase
  end
  assign wb_dat_o = rdat_ff;
endmodule : psp_top

/* dv/psp_monitor.sv */
// Purpose: port-level checks of the slave port top.
// Assumes: single clock, sync reset high.
// Notes:   Mode and enables tracked from acked bus writes.
`include "psp_defs.svh"
`timescale 1ns/1ps
module psp_monitor (
  input wire logic clk_i,                   // System clock
  input wire logic rst_i,                   // Sync reset
  input wire logic wb_cyc_i,                // Bus cycle
  input wire logic wb_stb_i,                // Strobe
  input wire logic wb_we_i,                 // Write enable
  input wire logic [5:0] wb_adr_i,          // Address
  input wire logic [3:0] wb_sel_i,          // Byte enables
  input wire logic [31:0] wb_dat_i,         // Write data
  input wire logic [31:0] wb_dat_o,         // Read data
  input wire logic wb_ack_o,                // Ack
  input wire logic wb_err_o,                // Error
  input wire psp_pkg::psp_sel_type sel_i,   // Master select
  input wire logic rd_n_i,                  // Read strobe
  input wire logic wr_n_i,                  // Write strobe
  input wire logic [7:0] pd_oe_n_o,         // Pin enable
  input wire logic attn_o,                  // Attention
  input wire logic in_empty_o,              // All read
  input wire logic out_pend_o,              // Pending
  input wire logic irq_o                    // Interrupt
);
  import psp_pkg::*;
  logic en_ff;
  logic [3:0] ien_ff;
  logic wr_ack;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Shadow of mode and mask; lags the design by one cycle, harmless
  assign wr_ack = wb_ack_o && wb_we_i && wb_sel_i[0];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_ff <= 1'b0;
      ien_ff <= 4'h0;
    end else if (wr_ack && wb_adr_i == `PSP_OFF_CTRL) begin
      en_ff <= wb_dat_i[0];
    end else if (wr_ack && wb_adr_i == `PSP_OFF_IRQ_EN) begin
      ien_ff <= wb_dat_i[3:0];
    end
  end
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_resp_a: assert property ($rose(wb_stb_i) |=> wb_ack_o || wb_err_o)
    else $error("bus request not answered");
  resp_excl_a: assert property (!(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  drive_read_a: assert property (en_ff && !rd_n_i && $past(!rd_n_i)
    && sel_i != 2'h3 |-> pd_oe_n_o == 8'h00) else $error("read not driven");
  read_release_a: assert property (en_ff && $rose(rd_n_i)
    |=> pd_oe_n_o == 8'hff) else $error("pins not released");
  attn_clear_a: assert property (en_ff && $rose(rd_n_i) && !wb_cyc_i
    |=> !attn_o) else $error("attention not cleared");
  empty_write_a: assert property (en_ff && $fell(wr_n_i)
    && sel_i != 2'h3 |=> !in_empty_o) else $error("empty after write");
  pend_write_a: assert property (wr_ack && wb_adr_i < `PSP_OFF_IN0
    |-> out_pend_o && attn_o) else $error("no pending after write");
  irq_write_a: assert property (en_ff && $fell(wr_n_i) && sel_i != 2'h3
    && ien_ff[sel_i] |=> irq_o) else $error("no interrupt on write");
  cover property (wb_err_o);
  cover property ($rose(irq_o));
  cover property (en_ff && $rose(rd_n_i));
endmodule : psp_monitor
bind psp_top psp_monitor i_psp_monitor (.*);

/* dv/psp_master_model.sv */
// Purpose: external master driving selects, strobes and pin data.
// Assumes: strobes change just after a rising edge.
// Notes:   Released pins show the inverse of the last byte.
`timescale 1ns/1ps
module psp_master_model (
  input wire logic clk_i,                  // System clock
  input wire psp_pkg::psp_byte_type pd_i,  // Wire level
  output psp_pkg::psp_sel_type sel_o,      // Register select
  output logic rd_n_o,                     // Read strobe
  output logic wr_n_o,                     // Write strobe
  output psp_pkg::psp_byte_type pd_o       // Master data
);
  import psp_pkg::*;
  initial begin
    sel_o = 2'h0;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    pd_o = 8'h00;
  end
  // One-cycle write strobe, data held a cycle beyond it
  task automatic m_write(input psp_sel_type s, input psp_byte_type d);
    @(posedge clk_i);
    sel_o <= s;
    pd_o <= d;
    wr_n_o <= 1'b0;
    @(posedge clk_i);
    wr_n_o <= 1'b1;
    @(posedge clk_i);
    pd_o <= ~d;
  endtask : m_write
  // Read with extra wait cycles so slow masters are covered too
  task automatic m_read(input psp_sel_type s, input int slow,
                        output psp_byte_type d);
    @(posedge clk_i);
    sel_o <= s;
    rd_n_o <= 1'b0;
    repeat (2 + slow) @(posedge clk_i);
    d = pd_i;
    rd_n_o <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask : m_read
endmodule : psp_master_model

/* dv/psp_top_test.sv */
// Purpose: self-checking bench of the slave port.
// Assumes: bus and master calls never overlap.
// Notes:   Master model sits on the shared pins.
`timescale 1ns/1ps
module psp_top_test;
  import psp_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, err;
  logic [5:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] wdat = 0, rdat, q;
  logic attn, in_empty, out_pend, irq, rd_n, wr_n, last_err;
  logic [7:0] oe_n;
  psp_sel_type msel;
  psp_byte_type m_pd, dev_pd, pd_w, got;
  int fail_count = 0, checks = 0;
  // Wire level: device wins when enabled, else the master's byte
  assign pd_w = !oe_n[0] ? dev_pd : m_pd;
  always #50 clk_i = ~clk_i;
  psp_top i_psp_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .sel_i(msel), .rd_n_i(rd_n), .wr_n_i(wr_n), .pd_i(pd_w),
    .pd_o(dev_pd), .pd_oe_n_o(oe_n), .attn_o(attn),
    .in_empty_o(in_empty), .out_pend_o(out_pend), .irq_o(irq));
  psp_master_model i_psp_master_model (.clk_i(clk_i), .pd_i(pd_w),
    .sel_o(msel), .rd_n_o(rd_n), .wr_n_o(wr_n), .pd_o(m_pd));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Classic single cycle; waits for ack or err, the watchdog ends hangs
  task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    wdat <= {24'h0, d};
    do @(posedge clk_i); while (!(ack === 1'b1 || err === 1'b1));
    q = rdat;
    last_err = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic finish_test;
    if (fail_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    #200000;
    fail_count++;
    finish_test;
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check({attn, in_empty, out_pend, irq}, 4'b0100);
    wb(1, 6'h1c, 8'h01);
    wb(1, 6'h24, 8'h0f);
    for (int k = 0; k < 3; k++) begin
      wb(1, 6'(4 * k), 8'(8'ha0 + k));
      check({attn, out_pend}, 2'b11);
    end
    wb(0, 6'h18, 8'h00);
    check(q, 32'h38);
    for (int k = 0; k < 3; k++) begin
      i_psp_master_model.m_read(2'(k), k, got);
      check(got, 8'(8'ha0 + k));
    end
    check({attn, out_pend}, 2'b00);
    wb(0, 6'h20, 8'h00);
    check(q, 32'h08);
    wb(1, 6'h28, 8'h0f);
    check(irq, 1'b0);
    for (int k = 0; k < 3; k++) begin
      i_psp_master_model.m_write(2'(k), 8'(8'h50 + k));
      check({in_empty, irq}, 2'b01);
    end
    wb(0, 6'h18, 8'h00);
    check(q, 32'h07);
    wb(0, 6'h20, 8'h00);
    check(q, 32'h07);
    for (int k = 0; k < 3; k++) begin
      wb(0, 6'(8'h0c + 4 * k), 8'h00);
      check(q, 32'(8'h50 + k));
      check(in_empty, k == 2);
    end
    i_psp_master_model.m_write(2'h3, 8'h99);
    check(in_empty, 1'b1);
    wb(1, 6'h28, 8'h0f);
    wb(1, 6'h24, 8'h00);
    i_psp_master_model.m_write(2'h1, 8'h77);
    check(irq, 1'b0);
    wb(0, 6'h20, 8'h00);
    check(q, 32'h02);
    wb(1, 6'h00, 8'h11);
    wb(1, 6'h1c, 8'h03);
    check({attn, out_pend}, 2'b01);
    wb(0, 6'h1c, 8'h00);
    check(q, 32'h01);
    wb(0, 6'h30, 8'h00);
    check(last_err, 1'b1);
    wb(1, 6'h1c, 8'h00);
    wb(1, 6'h2c, 8'h3c);
    // Pin register follows port A one edge after the write lands
    @(posedge clk_i);
    check({oe_n, dev_pd}, 16'h003c);
    wb(0, 6'h2c, 8'h00);
    check(q, 32'h3c);
    finish_test;
  end
endmodule : psp_top_test
